// ==== design/alarm_pkg.sv ====
// shared constants, settings and state types for the temperature alarm outputs
package alarm_pkg;
    // alert response command byte (response address plus read bit)
    localparam logic [7:0] ALERT_RESPONSE_CMD = 8'h19;
    // slave address returned during the alert response
    localparam logic [6:0] SLAVE_ADDR_RESET = 7'h4c;
    // configuration bit positions
    localparam int CFG_SELECT_BIT = 5;
    localparam int CFG_MASK_BIT = 7;
    // status bit positions
    localparam int STATUS_LOW_BIT = 3;
    localparam int STATUS_OPEN_BIT = 2;
    localparam int STATUS_HIGH_BIT = 4;
    // reset values of the settings
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] HYST_RESET = 8'h0a;
    localparam logic [1:0] CONSEC_RESET = 2'h0;
    localparam logic [7:0] THERMAL_SHUTDOWN_OUT_LIMIT_RESET = 8'h7f;
    localparam logic [7:0] HIGH_LIMIT_RESET = 8'h7f;
    localparam logic [7:0] LOW_LIMIT_RESET = 8'h00;
    // link bit counter end value (eight bits per byte)
    localparam logic [2:0] LAST_BIT = 3'h7;

    // programmable settings, index 0 local, 1 remote
    typedef struct packed {
        logic [7:0] cfg_bits;
        logic [7:0] hyst;
        logic [1:0] consec_code;
        logic [1:0][7:0] thermal_shutdown_out_limit;
        logic [1:0][7:0] high_limit;
        logic [1:0][7:0] low_limit;
    } settings_type;

    // one finished conversion result
    typedef struct packed {
        logic valid;
        logic channel;
        logic [7:0] temp;
    } conversion_type;

    // status flags seen by software
    typedef struct packed {
        logic [7:0] bits;
    } status_type;

    // phases of the alert response on the link
    typedef enum logic [2:0] {LINK_IDLE, LINK_CMD, LINK_CMD_ACK, LINK_ADDR, LINK_ADDR_ACK} link_phase_type;

    // state of the link clock domain
    typedef struct packed {
        link_phase_type phase;
        logic [2:0] bit_cnt;
        logic [7:0] shreg;
        logic sda_drive;
        logic win_toggle;
        logic [1:0] req_s1;
        logic [1:0] req_s2;
        logic [1:0] req_s3;
        logic [1:0] req_held;
    } link_state_type;

    // state of the core clock domain
    typedef struct packed {
        settings_type cfg;
        logic [1:0][7:0] last_temp;
        logic fault_seen;
        logic open_now;
        logic [1:0] viol_now;
        logic [1:0][2:0] viol_cnt;
        logic [1:0] thermal_shutdown_out_act;
        logic [1:0] th2_act;
        logic alert_act;
        logic alert_high;
        status_type status;
        logic win_s1;
        logic win_s2;
        logic win_s3;
        logic win_acc;
        logic abort;
        logic thermal_shutdown_out_oe_n;
        logic pin6_oe_n;
    } core_state_type;
endpackage : alarm_pkg

// ==== design/temperature_alarm_outputs.sv ====
// alarm output logic with alert response on the serial link
//
// Behaviour
// - acknowledge alert command, then return own address
// - address lsb shows high or low cause
// - arbitrate address; winner clears warning, loser keeps
// - both alarm pins open drain, low only
// - thermal output can never be masked
// - config bit 5 selects pin six function
// - thermal output low at or above thermal limit
// - thermal release at or below limit minus hysteresis
// - second thermal mode uses high/low limits
// - warning on high or low limit violation
// - warning needs one to four consecutive violations
// - warning also on open remote sensor
// - config bit 7 masks the warning
// - warning clears on response when condition gone
// - diode fault keeps last remote value, flags open
// - general call reset restores defaults, releases pins
`timescale 1ns/1ns
module temperature_alarm_outputs (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic link_clk,
    input wire alarm_pkg::conversion_type conv,
    input wire logic diode_fault,
    input wire logic settings_write,
    input wire alarm_pkg::settings_type settings_in,
    input wire logic status_clear,
    input wire logic general_call_reset,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic thermal_shutdown_out,
    output logic thermal_shutdown_oe_n,
    output logic warning_or_second_thermal_out,
    output logic warning_or_second_thermal_oe_n,
    output alarm_pkg::status_type status,
    output logic [7:0] remote_temp,
    output logic conversion_abort
);
    // state registers of both domains
    alarm_pkg::core_state_type core_reg;
    alarm_pkg::core_state_type core_next;
    alarm_pkg::link_state_type link_reg;
    alarm_pkg::link_state_type link_next;
    // data line as seen at the last rising link clock
    logic sda_at_rise_reg;
    // warning request level and cause bit handed to the link
    logic [1:0] alert_req;
    // default settings after any reset
    localparam alarm_pkg::settings_type SETTINGS_RESET = '{
        cfg_bits: alarm_pkg::CFG_RESET,
        hyst: alarm_pkg::HYST_RESET,
        consec_code: alarm_pkg::CONSEC_RESET,
        thermal_shutdown_out_limit: {alarm_pkg::THERMAL_SHUTDOWN_OUT_LIMIT_RESET, alarm_pkg::THERMAL_SHUTDOWN_OUT_LIMIT_RESET},
        high_limit: {alarm_pkg::HIGH_LIMIT_RESET, alarm_pkg::HIGH_LIMIT_RESET},
        low_limit: {alarm_pkg::LOW_LIMIT_RESET, alarm_pkg::LOW_LIMIT_RESET}
    };

    // limit minus hysteresis, floored at zero
    function automatic logic [7:0] sub_floor(input logic [7:0] a, input logic [7:0] b);
        sub_floor = (a > b) ? 8'(a - b) : 8'h00;
    endfunction : sub_floor

    // limit plus hysteresis, capped at full scale
    function automatic logic [7:0] add_cap(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        add_cap = sum[8] ? 8'hff : sum[7:0];
    endfunction : add_cap

    // core domain next state
    always_comb begin
        logic [7:0] t;
        logic ch;
        logic [2:0] need;
        logic hi;
        logic lo;
        logic win_evt;
        logic second_mode;
        logic masked;
        t = 8'h00;
        ch = 1'b0;
        hi = 1'b0;
        lo = 1'b0;
        need = 3'h0;
        win_evt = 1'b0;
        second_mode = 1'b0;
        masked = 1'b0;
        core_next = core_reg;
        need = {1'b0, core_reg.cfg.consec_code} + 3'h1;
        // win toggle: 3 flops, counted once stages 2 and 3 agree
        core_next.win_s1 = link_reg.win_toggle;
        core_next.win_s2 = core_reg.win_s1;
        core_next.win_s3 = core_reg.win_s2;
        win_evt = (core_reg.win_s2 == core_reg.win_s3) && (core_reg.win_s3 != core_reg.win_acc);
        if (win_evt) begin
            core_next.win_acc = core_reg.win_s3;
        end
        core_next.abort = 1'b0;
        if (settings_write) begin
            core_next.cfg = settings_in;
        end
        // diode comparator is watched all through a conversion
        if (diode_fault) begin
            core_next.fault_seen = 1'b1;
        end
        if (conv.valid) begin
            ch = conv.channel;
            t = conv.temp;
            if (ch && (core_reg.fault_seen || diode_fault)) begin
                t = core_reg.last_temp[1];
                core_next.open_now = 1'b1;
            end else if (ch) begin
                core_next.open_now = 1'b0;
            end
            if (ch) begin
                core_next.fault_seen = 1'b0;
            end
            core_next.last_temp[ch] = t;
            hi = t >= core_reg.cfg.high_limit[ch];
            lo = t < core_reg.cfg.low_limit[ch];
            core_next.viol_now[ch] = hi || lo;
            if (t >= core_reg.cfg.thermal_shutdown_out_limit[ch]) begin
                core_next.thermal_shutdown_out_act[ch] = 1'b1;
            end else if (t <= sub_floor(core_reg.cfg.thermal_shutdown_out_limit[ch], core_reg.cfg.hyst)) begin
                core_next.thermal_shutdown_out_act[ch] = 1'b0;
            end
            // same behaviour, high and low limits
            if (hi || lo) begin
                core_next.th2_act[ch] = 1'b1;
            end else if (t <= sub_floor(core_reg.cfg.high_limit[ch], core_reg.cfg.hyst)
                         && t >= add_cap(core_reg.cfg.low_limit[ch], core_reg.cfg.hyst)) begin
                core_next.th2_act[ch] = 1'b0;
            end
            if (hi || lo) begin
                if (core_reg.viol_cnt[ch] < 3'h4) begin
                    core_next.viol_cnt[ch] = core_reg.viol_cnt[ch] + 3'h1;
                end
            end else begin
                core_next.viol_cnt[ch] = 3'h0;
            end
        end
        // clear on won response only when cause gone; set wins below
        if (win_evt && !(|core_reg.viol_now) && !core_reg.open_now && core_reg.status.bits == 8'h00) begin
            core_next.alert_act = 1'b0;
        end
        // status flags: clearing loses against a new event
        if (status_clear) begin
            core_next.status.bits = 8'h00;
        end
        if (conv.valid && (hi || lo)) begin
            core_next.status.bits[alarm_pkg::STATUS_HIGH_BIT] = core_reg.status.bits[alarm_pkg::STATUS_HIGH_BIT]
                && !status_clear || hi;
            core_next.status.bits[alarm_pkg::STATUS_LOW_BIT] = core_reg.status.bits[alarm_pkg::STATUS_LOW_BIT]
                && !status_clear || lo;
        end
        if (conv.valid && (hi || lo) && core_next.viol_cnt[ch] >= need) begin
            core_next.alert_act = 1'b1;
            core_next.alert_high = hi;
        end
        // open sensor raises warning and flag
        if (core_next.open_now) begin
            core_next.alert_act = 1'b1;
            core_next.status.bits[alarm_pkg::STATUS_OPEN_BIT] = 1'b1;
        end
        if (general_call_reset) begin
            core_next = '0;
            core_next.cfg = SETTINGS_RESET;
            core_next.win_s1 = link_reg.win_toggle;
            core_next.win_s2 = core_reg.win_s1;
            core_next.win_s3 = core_reg.win_s2;
            core_next.win_acc = core_reg.win_s3;
            core_next.abort = 1'b1;
        end
        second_mode = core_next.cfg.cfg_bits[alarm_pkg::CFG_SELECT_BIT]
            && !core_next.cfg.cfg_bits[alarm_pkg::CFG_MASK_BIT];
        masked = core_next.cfg.cfg_bits[alarm_pkg::CFG_MASK_BIT];
        // thermal pin has no enable or mask
        core_next.thermal_shutdown_out_oe_n = !(|core_next.thermal_shutdown_out_act);
        if (second_mode) begin
            core_next.pin6_oe_n = !(|core_next.th2_act);
        end else begin
            core_next.pin6_oe_n = masked || !core_next.alert_act;
        end
    end

    // core registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_reg <= '0;
            core_reg.cfg <= SETTINGS_RESET;
            core_reg.thermal_shutdown_out_oe_n <= 1'b1;
            core_reg.pin6_oe_n <= 1'b1;
        end else begin
            core_reg <= core_next;
        end
    end

    // only an unmasked warning in warning mode is answered on the link
    assign alert_req = {!core_reg.pin6_oe_n && !core_reg.cfg.cfg_bits[alarm_pkg::CFG_SELECT_BIT],
                        core_reg.alert_high};

    // open drain: value low, enable low only while asserted
    assign thermal_shutdown_out = 1'b0;
    assign thermal_shutdown_oe_n = core_reg.thermal_shutdown_out_oe_n;
    assign warning_or_second_thermal_out = 1'b0;
    assign warning_or_second_thermal_oe_n = core_reg.pin6_oe_n;
    assign status = core_reg.status;
    assign remote_temp = core_reg.last_temp[1];
    assign conversion_abort = core_reg.abort;

    // data line captured at each rising link clock
    always_ff @(posedge link_clk) begin
        if (reset) begin
            sda_at_rise_reg <= 1'b1;
        end else begin
            sda_at_rise_reg <= sda_in;
        end
    end

    // link next state, evaluated at each falling link clock
    always_comb begin
        logic b;
        logic start;
        logic [7:0] byte_in;
        b = sda_at_rise_reg;
        // data fell while clock was high: start condition
        start = sda_at_rise_reg && !sda_in;
        byte_in = {link_reg.shreg[6:0], b};
        link_next = link_reg;
        link_next.req_s1 = alert_req;
        link_next.req_s2 = link_reg.req_s1;
        link_next.req_s3 = link_reg.req_s2;
        if (link_reg.req_s2 == link_reg.req_s3) begin
            link_next.req_held = link_reg.req_s3;
        end
        if (start) begin
            link_next.phase = alarm_pkg::LINK_CMD;
            link_next.bit_cnt = 3'h0;
            link_next.sda_drive = 1'b0;
        end else begin
            case (link_reg.phase)
                alarm_pkg::LINK_CMD: begin
                    link_next.shreg = byte_in;
                    link_next.bit_cnt = link_reg.bit_cnt + 3'h1;
                    if (link_reg.bit_cnt == alarm_pkg::LAST_BIT) begin
                        if (byte_in == alarm_pkg::ALERT_RESPONSE_CMD && link_reg.req_held[1]) begin
                            link_next.phase = alarm_pkg::LINK_CMD_ACK;
                            link_next.sda_drive = 1'b1;
                        end else begin
                            link_next.phase = alarm_pkg::LINK_IDLE;
                        end
                    end
                end
                alarm_pkg::LINK_CMD_ACK: begin
                    // address with cause bit as lsb
                    link_next.shreg = {alarm_pkg::SLAVE_ADDR_RESET, link_reg.req_held[0]};
                    link_next.sda_drive = !alarm_pkg::SLAVE_ADDR_RESET[6];
                    link_next.bit_cnt = 3'h0;
                    link_next.phase = alarm_pkg::LINK_ADDR;
                end
                alarm_pkg::LINK_ADDR: begin
                    // released one but bus low: lost
                    if (link_reg.shreg[7] && !b) begin
                        link_next.sda_drive = 1'b0;
                        link_next.phase = alarm_pkg::LINK_IDLE;
                    end else if (link_reg.bit_cnt == alarm_pkg::LAST_BIT) begin
                        link_next.sda_drive = 1'b0;
                        link_next.phase = alarm_pkg::LINK_ADDR_ACK;
                    end else begin
                        link_next.shreg = {link_reg.shreg[6:0], 1'b0};
                        link_next.sda_drive = !link_reg.shreg[6];
                        link_next.bit_cnt = link_reg.bit_cnt + 3'h1;
                    end
                end
                alarm_pkg::LINK_ADDR_ACK: begin
                    // won: tell core at command end
                    link_next.win_toggle = !link_reg.win_toggle;
                    link_next.phase = alarm_pkg::LINK_IDLE;
                end
                default: begin
                    link_next.phase = alarm_pkg::LINK_IDLE;
                    link_next.sda_drive = 1'b0;
                end
            endcase
        end
    end

    // link registers change while the link clock is low
    always_ff @(negedge link_clk) begin
        if (reset) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    // data line: only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe_n = !link_reg.sda_drive;

    // thermal output follows any channel over its thermal limit
    property thermal_shutdown_out_set_p;
        @(posedge ref_clk) disable iff (reset)
        (conv.valid && !general_call_reset && !(conv.channel && (core_reg.fault_seen || diode_fault))
         && conv.temp >= core_reg.cfg.thermal_shutdown_out_limit[conv.channel]) |=> !thermal_shutdown_oe_n;
    endproperty
    thermal_shutdown_out_set_a: assert property (thermal_shutdown_out_set_p) else $error("thermal output missed a limit crossing");
    thermal_shutdown_out_release_a: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(thermal_shutdown_oe_n) |-> $past(conv.valid) || $past(general_call_reset))
        else $error("thermal output released without a conversion");
    thermal_shutdown_out_unmasked_a: assert property (@(posedge ref_clk) disable iff (reset)
        (|core_reg.thermal_shutdown_out_act) |-> !thermal_shutdown_oe_n) else $error("thermal output masked");
    warn_mask_a: assert property (@(posedge ref_clk) disable iff (reset)
        core_reg.cfg.cfg_bits[alarm_pkg::CFG_MASK_BIT] |-> warning_or_second_thermal_oe_n)
        else $error("masked warning asserted");
    second_thermal_shutdown_out_a: assert property (@(posedge ref_clk) disable iff (reset)
        (core_reg.cfg.cfg_bits[alarm_pkg::CFG_SELECT_BIT] && !core_reg.cfg.cfg_bits[alarm_pkg::CFG_MASK_BIT])
        |-> warning_or_second_thermal_oe_n == !(|core_reg.th2_act)) else $error("second thermal mismatch");
    consec_filter_a: assert property (@(posedge ref_clk) disable iff (reset)
        ($rose(core_reg.alert_act) && !core_reg.open_now)
        |-> (core_reg.viol_cnt[0] > {1'b0, core_reg.cfg.consec_code}
             || core_reg.viol_cnt[1] > {1'b0, core_reg.cfg.consec_code}))
        else $error("warning before enough violations");
    open_alert_a: assert property (@(posedge ref_clk) disable iff (reset)
        (conv.valid && conv.channel && !general_call_reset && (core_reg.fault_seen || diode_fault))
        |=> core_reg.alert_act && status.bits[alarm_pkg::STATUS_OPEN_BIT] && $stable(remote_temp))
        else $error("diode fault not flagged");
    gc_release_a: assert property (@(posedge ref_clk) disable iff (reset)
        general_call_reset |=> thermal_shutdown_oe_n && warning_or_second_thermal_oe_n && conversion_abort)
        else $error("general call reset left an alarm asserted");
    cmd_ack_a: assert property (@(negedge link_clk) disable iff (reset)
        (link_reg.phase == alarm_pkg::LINK_CMD && link_reg.bit_cnt == alarm_pkg::LAST_BIT
         && !(sda_at_rise_reg && !sda_in) && link_reg.req_held[1]
         && {link_reg.shreg[6:0], sda_at_rise_reg} == alarm_pkg::ALERT_RESPONSE_CMD)
        |=> !sda_oe_n ##1 link_reg.phase == alarm_pkg::LINK_ADDR) else $error("alert command not acknowledged");
    arb_lost_a: assert property (@(negedge link_clk) disable iff (reset)
        (link_reg.phase == alarm_pkg::LINK_ADDR && link_reg.shreg[7] && !sda_at_rise_reg)
        |=> sda_oe_n && link_reg.phase == alarm_pkg::LINK_IDLE && $stable(link_reg.win_toggle))
        else $error("lost arbitration not released");
    cover_warn_c: cover property (@(posedge ref_clk) disable iff (reset) $fell(warning_or_second_thermal_oe_n));
    cover_thermal_shutdown_out_c: cover property (@(posedge ref_clk) disable iff (reset) $rose(thermal_shutdown_oe_n));
    cover_win_c: cover property (@(negedge link_clk) disable iff (reset)
        link_reg.phase == alarm_pkg::LINK_ADDR_ACK);
    cover_lost_c: cover property (@(negedge link_clk) disable iff (reset)
        link_reg.phase == alarm_pkg::LINK_ADDR ##1 link_reg.phase == alarm_pkg::LINK_IDLE);
endmodule : temperature_alarm_outputs

// ==== dv/smbus_host_model.sv ====
// host side model: drives the link clock and runs alert responses
`timescale 1ns/1ns
module smbus_host_model (
    output logic link_clk,
    output logic sda_line,
    input wire logic dev_sda_oe_n
);
    logic sda_host; // host data drive, 1 = released
    // wired data line with pull-up: any party pulling low wins
    assign sda_line = sda_host & dev_sda_oe_n;
    // clock stands high and the line is released outside frames
    initial begin
        link_clk = 1'b1;
        sda_host = 1'b1;
    end
    // one bit slot: data changes mid-low, sampled at the rise
    // never at the fall itself, where the device would take a drop as a start
    task automatic slot(input logic b, output logic s);
        #16;
        sda_host = b;
        #16;
        link_clk = 1'b1;
        s = sda_line;
        #32;
        link_clk = 1'b0;
    endtask : slot
    // free toggling with the line released, so reset reaches the link side
    task automatic run(input int n);
        repeat (n) begin
            link_clk = 1'b0;
            #32;
            link_clk = 1'b1;
            #32;
        end
    endtask : run
    // command then address read
    // lose pulls the first address bit low, as a rival device would
    task automatic respond(input logic [7:0] cmd, input logic lose, output logic ack_n, output logic [7:0] addr);
        logic s;
        link_clk = 1'b0;
        sda_host = 1'b1;
        #32;
        link_clk = 1'b1;
        #16;
        sda_host = 1'b0;
        #16;
        link_clk = 1'b0;
        for (int i = 7; i >= 0; i--) slot(cmd[i], s);
        slot(1'b1, ack_n);
        for (int i = 7; i >= 0; i--) slot(!(lose && i == 7), addr[i]);
        // master not-acknowledge ends the read, then stop
        slot(1'b1, s);
        #16;
        sda_host = 1'b0;
        #16;
        link_clk = 1'b1;
        #16;
        sda_host = 1'b1;
    endtask : respond
endmodule : smbus_host_model

// ==== dv/tb_top.sv ====
// self-checking bench for the temperature alarm outputs
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic link_clk;
    logic sda_line;
    logic sda_oe_n;
    logic th_n; // thermal pin enable, low = asserted
    logic pin6_n; // pin six enable, low = asserted
    logic diode_fault = 1'b0;
    logic settings_write = 1'b0;
    logic status_clear = 1'b0;
    logic general_call_reset = 1'b0;
    logic abort;
    logic ack_n;
    logic hi;
    logic ch;
    logic seen;
    logic [7:0] addr;
    logic [2:0] drv; // value pins of the open drain outputs, must stay low
    logic [7:0] cmd;
    logic [7:0] remote_temp;
    logic [7:0] lim;
    alarm_pkg::conversion_type conv = '0;
    alarm_pkg::settings_type st;
    alarm_pkg::status_type status;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    smbus_host_model host (.link_clk(link_clk), .sda_line(sda_line), .dev_sda_oe_n(sda_oe_n));
    temperature_alarm_outputs uut (.ref_clk(ref_clk), .reset(reset), .link_clk(link_clk), .conv(conv),
        .diode_fault(diode_fault), .settings_write(settings_write), .settings_in(st),
        .status_clear(status_clear), .general_call_reset(general_call_reset), .sda_in(sda_line),
        .sda_out(drv[0]), .sda_oe_n(sda_oe_n), .thermal_shutdown_out(drv[1]), .thermal_shutdown_oe_n(th_n),
        .warning_or_second_thermal_out(drv[2]), .warning_or_second_thermal_oe_n(pin6_n), .status(status),
        .remote_temp(remote_temp), .conversion_abort(abort));

    // 125 MHz core clock
    always #4 ref_clk = ~ref_clk;
    // hang guard, well above the expected few thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    // wait n edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // one conversion result; outputs settle one edge later
    task automatic cv(input logic c, input logic [7:0] t);
        conv = '{1'b1, c, t};
        tick(1);
        conv.valid = 1'b0;
        tick(1);
    endtask : cv
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask : pulse
    // reset long enough for both domains, then default settings image
    task automatic rst();
        reset = 1'b1;
        host.run(3);
        tick(16);
        reset = 1'b0;
        st = '{8'h00, 8'h0a, 2'h0, {2{8'h7f}}, {2{8'h7f}}, {2{8'h00}}};
    endtask : rst
    // alert response, then room for the result to cross into the core
    task automatic resp(input logic [7:0] c, input logic lose);
        host.respond(c, lose, ack_n, addr);
        tick(10);
    endtask : resp
    // address byte expected back: own address, cause in the lsb
    function automatic logic [7:0] exp_addr(input logic h);
        return {alarm_pkg::SLAVE_ADDR_RESET, h};
    endfunction : exp_addr

    initial begin
        lim = 8'($urandom(32'hc0207524));
        rst();
        // released pins and cleared flags after reset
        `CHECK("th", 1'b1, th_n)
        `CHECK("pin6", 1'b1, pin6_n)
        `CHECK("sda", 1'b1, sda_oe_n)
        `CHECK("status", 8'h00, status.bits)
        // thermal trips at the limit even with the warning masked
        lim = 8'd40 + 8'($urandom % 80);
        ch = 1'($urandom);
        st.cfg_bits = 8'h80;
        st.thermal_shutdown_out_limit = {2{lim}};
        st.high_limit = {2{lim - 8'd20}};
        pulse(settings_write);
        cv(ch, lim);
        `CHECK("th set", 1'b0, th_n)
        `CHECK("th unmasked", 1'b0, th_n)
        `CHECK("pin6 masked", 1'b1, pin6_n)
        cv(ch, lim - 8'd9);
        `CHECK("th hold", 1'b0, th_n)
        cv(ch, lim - 8'd10);
        `CHECK("th release", 1'b1, th_n)
        // general call reset: pins free, abort pulse, defaults back
        cv(ch, lim);
        general_call_reset = 1'b1;
        tick(1);
        general_call_reset = 1'b0;
        seen = abort;
        tick(1);
        seen = seen | abort;
        `CHECK("abort", 1'b1, seen)
        `CHECK("th gc", 1'b1, th_n)
        cv(ch, 8'h7e);
        `CHECK("th default", 1'b1, th_n)
        // every consecutive count: boundary value is a violation
        for (int k = 0; k < 4; k++) begin
            rst();
            st.consec_code = 2'(k);
            st.high_limit = {2{8'd50}};
            pulse(settings_write);
            repeat (k) cv(1'b0, 8'd60 + 8'($urandom % 60));
            `CHECK("pin6 early", 1'b1, pin6_n)
            cv(1'b0, 8'd50);
            `CHECK("pin6 count", 1'b0, pin6_n)
        end
        // alert response for a low cause and a high cause
        for (int h = 0; h < 2; h++) begin
            hi = 1'(h);
            rst();
            st.low_limit = {2{8'd30}};
            st.high_limit = {2{8'd90}};
            pulse(settings_write);
            cv(1'b1, hi ? 8'd90 : 8'd29);
            `CHECK("pin6 warn", 1'b0, pin6_n)
            `CHECK("flag", 1'b1, status.bits[hi ? alarm_pkg::STATUS_HIGH_BIT : alarm_pkg::STATUS_LOW_BIT])
            resp(8'h19, 1'b0);
            `CHECK("ack", 1'b0, ack_n)
            `CHECK("addr", exp_addr(hi), addr)
            `CHECK("pin6 cause", 1'b0, pin6_n)
            cv(1'b1, 8'd60);
            resp(8'h19, 1'b0);
            `CHECK("pin6 flags", 1'b0, pin6_n)
            pulse(status_clear);
            resp(8'h19, 1'b1);
            `CHECK("pin6 lost", 1'b0, pin6_n)
            cmd = 8'($urandom);
            if (cmd == 8'h19) cmd = 8'h18;
            resp(cmd, 1'b0);
            `CHECK("nack", 1'b1, ack_n)
            resp(8'h19, 1'b0);
            `CHECK("pin6 won", 1'b1, pin6_n)
        end
        // open remote diode keeps the last value and warns
        rst();
        lim = 8'($urandom % 100);
        cv(1'b1, lim);
        diode_fault = 1'b1;
        cv(1'b1, lim + 8'd5);
        diode_fault = 1'b0;
        `CHECK("remote", lim, remote_temp)
        `CHECK("open", 1'b1, status.bits[alarm_pkg::STATUS_OPEN_BIT])
        `CHECK("pin6 open", 1'b0, pin6_n)
        // second thermal mode with hysteresis on both limits
        rst();
        st.cfg_bits = 8'h20;
        st.high_limit = {2{8'd80}};
        st.low_limit = {2{8'd20}};
        pulse(settings_write);
        cv(1'b0, 8'd80);
        `CHECK("t2 high", 1'b0, pin6_n)
        cv(1'b0, 8'd71);
        `CHECK("t2 hold", 1'b0, pin6_n)
        cv(1'b0, 8'd70);
        `CHECK("t2 free", 1'b1, pin6_n)
        cv(1'b0, 8'd19);
        `CHECK("t2 low", 1'b0, pin6_n)
        `CHECK("pin drive", 3'h0, drv)
        cv(1'b0, 8'd30);
        `CHECK("t2 back", 1'b1, pin6_n)
        report_and_stop();
    end
endmodule : tb_top
